/* hdl/cgr_pkg.sv */
package cgr_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int          CGR_ADDR_W          = 16;
    localparam int          CGR_DATA_W          = 64;
    localparam int          CGR_REQ_ADDR_W      = 32;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [15:0] CGR_OFF_ERR_MASK    = 16'h0040;
    localparam logic [15:0] CGR_OFF_CUST_BASE   = 16'h0060;
    localparam logic [15:0] CGR_OFF_CUST_STAT   = 16'h0068;
    localparam logic [15:0] CGR_OFF_ERR_CAUSE   = 16'h0080;
    localparam logic [15:0] CGR_OFF_ERR_MULT    = 16'h0088;
    localparam logic [15:0] CGR_OFF_PF_CTRL     = 16'h0300;
    localparam logic [15:0] CGR_OFF_PF_PORTS    = 16'h0308;
    localparam logic [15:0] CGR_OFF_SEMAPHORE   = 16'h0640;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          CGR_PF_COUNT_LSB    = 0;
    localparam int          CGR_PF_COUNT_W      = 8;
    localparam int          CGR_PF_ON_BIT       = 8;
    localparam int          CGR_PORT_SEL_LSB    = 0;
    localparam int          CGR_PORT_SEL_W      = 8;
    localparam int          CGR_CODE_PF_BIT     = 8;
    localparam int          CGR_SEM_W           = 32;
    localparam int          CGR_SEM_HELD_BIT    = 31;
    localparam int          CGR_CUST_ON_BIT     = 0;
    localparam int          CGR_CUST_BASE_LSB   = 16;
    localparam int          CGR_CUST_BASE_W     = 16;
    localparam int          CGR_CUST_PRES_BIT   = 0;
    localparam int          CGR_ERR_TYPE_LSB    = 58;
    localparam int          CGR_ERR_TYPE_W      = 6;
    localparam int          CGR_ERR_INFO_W      = 58;

    // ----------------------------------------------------------------
    // error type codes
    // ----------------------------------------------------------------
    localparam logic [5:0]  CGR_ERR_NONE        = 6'h00;
    localparam logic [5:0]  CGR_ERR_L2_FIXABLE  = 6'h01;
    localparam logic [5:0]  CGR_ERR_REQ_DECODE  = 6'h02;
    localparam logic [5:0]  CGR_ERR_L2_FATAL    = 6'h03;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [63:0] CGR_RST_MASK        = 64'h0000_0000_0000_0000;
    localparam logic [31:0] CGR_RST_SEM         = 32'h0000_0000;
    localparam logic [7:0]  CGR_RST_PORTS       = 8'h00;
    localparam logic [63:0] CGR_RD_ZERO         = 64'h0000_0000_0000_0000;

endpackage

/* hdl/cgr_global_regs.sv */
`timescale 1ns/1ps

module cgr_global_regs
    import cgr_pkg::*;
#(
    parameter logic [7:0]  PREFETCH_UNITS  = 8'h02,
    parameter int          NUM_CORES       = 4,
    parameter int          NUM_IO_UNITS    = 2,
    parameter logic        CUSTOM_PRESENT  = 1'b1
)
(
    input  wire logic                          clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic [CGR_ADDR_W-1:0]         reg_addr_in,
    input  wire logic [CGR_DATA_W-1:0]         reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [CGR_DATA_W-1:0]         reg_rdata_out,
    input  wire logic                          err_valid_in,
    input  wire logic [CGR_ERR_TYPE_W-1:0]     err_type_in,
    input  wire logic [CGR_ERR_INFO_W-1:0]     err_detail_in,
    input  wire logic                          req_valid_in,
    input  wire logic [CGR_REQ_ADDR_W-1:0]     req_addr_in,
    output logic                               prefetch_on_out,
    output logic                               code_prefetch_on_out,
    output logic      [CGR_PORT_SEL_W-1:0]     prefetch_port_select_out,
    output logic                               custom_region_on_out,
    output logic      [CGR_CUST_BASE_W-1:0]    custom_base_out,
    output logic                               custom_hit_out,
    output logic                               err_response_out,
    output logic                               err_corrected_out,
    output logic                               err_irq_out
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [CGR_ADDR_W-1:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [CGR_ERR_TYPE_W-1:0] type_field(input logic [CGR_DATA_W-1:0] d);
        type_field = d[CGR_ERR_TYPE_LSB +: CGR_ERR_TYPE_W];
    endfunction

    // implemented ports: cores from bit 0, then io units, the rest unused
    function automatic logic [CGR_PORT_SEL_W-1:0] port_mask();
        logic [CGR_PORT_SEL_W-1:0] m;
        m = '0;
        for (int i = 0; i < CGR_PORT_SEL_W; i++)
        begin
            if (i < NUM_CORES + NUM_IO_UNITS)
            begin
                m[i] = 1'b1;
            end
        end
        port_mask = m;
    endfunction

    localparam logic [CGR_PORT_SEL_W-1:0] PORT_MASK = port_mask();
    localparam logic                      HAVE_PF   = (PREFETCH_UNITS != 8'h00);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [CGR_DATA_W-1:0]         err_mask;
    logic                          pf_on_bit;
    logic [CGR_PORT_SEL_W-1:0]     port_sel;
    logic                          code_pf_bit;
    logic [CGR_SEM_W-1:0]          semaphore;
    logic [CGR_CUST_BASE_W-1:0]    cust_base;
    logic                          cust_on;
    logic [CGR_ERR_TYPE_W-1:0]     cause_type;
    logic [CGR_ERR_INFO_W-1:0]     cause_detail;
    logic [CGR_ERR_TYPE_W-1:0]     mult_type;

    logic                          wr_mask;
    logic                          wr_base;
    logic                          wr_cause;
    logic                          wr_pf_ctrl;
    logic                          wr_ports;
    logic                          wr_sem;

    assign wr_mask    = reg_wr_in && hit(reg_addr_in, CGR_OFF_ERR_MASK);
    assign wr_base    = reg_wr_in && hit(reg_addr_in, CGR_OFF_CUST_BASE);
    assign wr_cause   = reg_wr_in && hit(reg_addr_in, CGR_OFF_ERR_CAUSE);
    assign wr_pf_ctrl = reg_wr_in && hit(reg_addr_in, CGR_OFF_PF_CTRL);
    assign wr_ports   = reg_wr_in && hit(reg_addr_in, CGR_OFF_PF_PORTS);
    assign wr_sem     = reg_wr_in && hit(reg_addr_in, CGR_OFF_SEMAPHORE);

    // ----------------------------------------------------------------
    // error mask
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            err_mask <= CGR_RST_MASK;
        end
        else if (wr_mask)
        begin
            err_mask <= reg_wdata_in;
        end
    end

    // ----------------------------------------------------------------
    // prefetch control
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            pf_on_bit <= 1'b0;
        end
        else if (wr_pf_ctrl)
        begin
            pf_on_bit <= reg_wdata_in[CGR_PF_ON_BIT];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            port_sel    <= CGR_RST_PORTS;
            code_pf_bit <= 1'b0;
        end
        else if (wr_ports)
        begin
            port_sel    <= reg_wdata_in[CGR_PORT_SEL_LSB +: CGR_PORT_SEL_W];
            code_pf_bit <= reg_wdata_in[CGR_CODE_PF_BIT];
        end
    end

    // count of zero means no prefetcher to steer, so the bit is inert
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            prefetch_on_out          <= 1'b0;
            code_prefetch_on_out     <= 1'b0;
            prefetch_port_select_out <= CGR_RST_PORTS;
        end
        else
        begin
            prefetch_on_out          <= pf_on_bit && HAVE_PF;
            code_prefetch_on_out     <= code_pf_bit && pf_on_bit && HAVE_PF;
            prefetch_port_select_out <= port_sel & PORT_MASK;
        end
    end

    // ----------------------------------------------------------------
    // hardware semaphore
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            semaphore <= CGR_RST_SEM;
        end
        else if (wr_sem)
        begin
            // a claim on a held lock is dropped, so the read-back shows the owner
            if (!(reg_wdata_in[CGR_SEM_HELD_BIT] && semaphore[CGR_SEM_HELD_BIT]))
            begin
                semaphore <= reg_wdata_in[CGR_SEM_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // custom block base and enable
    // ----------------------------------------------------------------
    // base has no reset on purpose: boot software must program it
    always_ff @(posedge clk_in)
    begin
        if (wr_base)
        begin
            cust_base <= reg_wdata_in[CGR_CUST_BASE_LSB +: CGR_CUST_BASE_W];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cust_on <= 1'b0;
        end
        else if (wr_base && CUSTOM_PRESENT)
        begin
            cust_on <= reg_wdata_in[CGR_CUST_ON_BIT];
        end
    end

    always_ff @(posedge clk_in)
    begin
        custom_base_out <= cust_base;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            custom_region_on_out <= 1'b0;
            custom_hit_out       <= 1'b0;
        end
        else
        begin
            custom_region_on_out <= cust_on;
            custom_hit_out       <= req_valid_in && cust_on
                && (req_addr_in[CGR_REQ_ADDR_W-1 -: CGR_CUST_BASE_W] == cust_base);
        end
    end

    // ----------------------------------------------------------------
    // error capture
    // ----------------------------------------------------------------
    logic                          clr_err;
    logic [CGR_ERR_TYPE_W-1:0]     held_type;
    logic [CGR_ERR_TYPE_W-1:0]     held_mult;
    logic                          new_err;

    // writing back the stored type acknowledges it
    assign clr_err   = wr_cause && (cause_type != CGR_ERR_NONE)
                       && (type_field(reg_wdata_in) == cause_type);
    assign held_type = clr_err ? CGR_ERR_NONE : cause_type;
    assign held_mult = clr_err ? CGR_ERR_NONE : mult_type;
    // type 0 is reserved and never captured
    assign new_err   = err_valid_in && (err_type_in != CGR_ERR_NONE);

    // an error in the clearing cycle lands after the clear, so it is kept
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cause_type   <= CGR_ERR_NONE;
            cause_detail <= '0;
            mult_type    <= CGR_ERR_NONE;
        end
        else
        begin
            cause_type <= held_type;
            mult_type  <= held_mult;
            if (new_err)
            begin
                if (held_type == CGR_ERR_NONE || held_type == CGR_ERR_L2_FIXABLE)
                begin
                    cause_type   <= err_type_in;
                    cause_detail <= err_detail_in;
                end
                else if (held_mult == CGR_ERR_NONE)
                begin
                    mult_type <= err_type_in;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // error responses and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            err_response_out  <= 1'b0;
            err_corrected_out <= 1'b0;
        end
        else
        begin
            err_response_out  <= err_valid_in && (err_type_in == CGR_ERR_REQ_DECODE);
            err_corrected_out <= err_valid_in && (err_type_in == CGR_ERR_L2_FIXABLE);
        end
    end

    // level while a masked-in type sits in the cause register
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            err_irq_out <= 1'b0;
        end
        else
        begin
            err_irq_out <= (cause_type != CGR_ERR_NONE) && err_mask[cause_type];
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [CGR_DATA_W-1:0] next_rdata;

    always_comb
    begin
        next_rdata = CGR_RD_ZERO;
        if (reg_rd_in)
        begin
            if (hit(reg_addr_in, CGR_OFF_ERR_MASK))
            begin
                next_rdata = err_mask;
            end
            else if (hit(reg_addr_in, CGR_OFF_CUST_BASE))
            begin
                next_rdata[CGR_CUST_BASE_LSB +: CGR_CUST_BASE_W] = cust_base;
                next_rdata[CGR_CUST_ON_BIT]                      = cust_on;
            end
            else if (hit(reg_addr_in, CGR_OFF_CUST_STAT))
            begin
                next_rdata[CGR_CUST_PRES_BIT] = CUSTOM_PRESENT;
            end
            else if (hit(reg_addr_in, CGR_OFF_ERR_CAUSE))
            begin
                next_rdata = {cause_type, cause_detail};
            end
            else if (hit(reg_addr_in, CGR_OFF_ERR_MULT))
            begin
                next_rdata[CGR_ERR_TYPE_LSB +: CGR_ERR_TYPE_W] = mult_type;
            end
            else if (hit(reg_addr_in, CGR_OFF_PF_CTRL))
            begin
                next_rdata[CGR_PF_COUNT_LSB +: CGR_PF_COUNT_W] = PREFETCH_UNITS;
                next_rdata[CGR_PF_ON_BIT]                      = pf_on_bit;
            end
            else if (hit(reg_addr_in, CGR_OFF_PF_PORTS))
            begin
                next_rdata[CGR_PORT_SEL_LSB +: CGR_PORT_SEL_W] = port_sel;
                next_rdata[CGR_CODE_PF_BIT]                    = code_pf_bit;
            end
            else if (hit(reg_addr_in, CGR_OFF_SEMAPHORE))
            begin
                next_rdata[CGR_SEM_W-1:0] = semaphore;
            end
        end
    end

    // data valid only in the cycle after the read strobe, zero otherwise
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            reg_rdata_out <= CGR_RD_ZERO;
        end
        else
        begin
            reg_rdata_out <= next_rdata;
        end
    end

endmodule

/* tb/cgr_global_regs_props.sv */
`timescale 1ns/1ps
module cgr_global_regs_props
    import cgr_pkg::*;
#(
    parameter logic [7:0] PREFETCH_UNITS = 8'h02,
    parameter int         NUM_CORES      = 4,
    parameter int         NUM_IO_UNITS   = 2,
    parameter logic       CUSTOM_PRESENT = 1'b1
)
(
    input wire logic                      clk_in,
    input wire logic                      sys_rst_in,
    input wire logic [CGR_ADDR_W-1:0]     reg_addr_in,
    input wire logic [CGR_DATA_W-1:0]     reg_wdata_in,
    input wire logic                      reg_wr_in,
    input wire logic                      reg_rd_in,
    input wire logic [CGR_DATA_W-1:0]     reg_rdata_out,
    input wire logic                      err_valid_in,
    input wire logic [CGR_ERR_TYPE_W-1:0] err_type_in,
    input wire logic [CGR_ERR_INFO_W-1:0] err_detail_in,
    input wire logic                      req_valid_in,
    input wire logic [CGR_REQ_ADDR_W-1:0] req_addr_in,
    input wire logic                      prefetch_on_out,
    input wire logic                      code_prefetch_on_out,
    input wire logic [CGR_PORT_SEL_W-1:0] prefetch_port_select_out,
    input wire logic                      custom_region_on_out,
    input wire logic [CGR_CUST_BASE_W-1:0] custom_base_out,
    input wire logic                      custom_hit_out,
    input wire logic                      err_response_out,
    input wire logic                      err_corrected_out,
    input wire logic                      err_irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    // outputs may be a registered copy, so allow one or two cycles of lag
    sequence recent_write;
        $past(reg_wr_in, 1) || $past(reg_wr_in, 2);
    endsequence
    sequence decode_evt;
        err_valid_in && err_type_in == CGR_ERR_REQ_DECODE;
    endsequence

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    read_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == CGR_RD_ZERO)
        else $error("read data not zero outside read cycle");
    unit_count_a: assert property (reg_rd_in && reg_addr_in == CGR_OFF_PF_CTRL |=> reg_rdata_out[7:0] == PREFETCH_UNITS)
        else $error("prefetch unit count wrong");
    prefetch_gate_a: assert property (reg_wr_in && reg_addr_in == CGR_OFF_PF_CTRL |=> ##1
        prefetch_on_out == ((PREFETCH_UNITS != 8'h00) && $past(reg_wdata_in[CGR_PF_ON_BIT], 2)))
        else $error("prefetch enable not followed as written");
    code_gate_a: assert property (code_prefetch_on_out |-> prefetch_on_out)
        else $error("code prefetch on without prefetch");
    ports_unused_a: assert property ((prefetch_port_select_out >> (NUM_CORES + NUM_IO_UNITS)) == 8'h00)
        else $error("unimplemented port selected");
    ctrl_stable_a: assert property (($changed(prefetch_on_out) || $changed(code_prefetch_on_out)
        || $changed(prefetch_port_select_out)) |-> recent_write)
        else $error("prefetch control changed without write");
    decode_resp_a: assert property (decode_evt |=> err_response_out)
        else $error("decode error without response");
    resp_cause_a: assert property (err_response_out |-> $past(err_valid_in) && $past(err_type_in) == CGR_ERR_REQ_DECODE)
        else $error("error response without decode error");
    fixable_fix_a: assert property (err_valid_in && err_type_in == CGR_ERR_L2_FIXABLE |=> err_corrected_out)
        else $error("correctable error not corrected");
    irq_cause_a: assert property ($rose(err_irq_out) |-> $past(err_valid_in, 2) || $past(reg_wr_in, 2))
        else $error("interrupt raised without cause");
    hit_cause_a: assert property (custom_hit_out |-> $past(req_valid_in))
        else $error("custom hit without request");
endmodule

/* tb/cgr_global_regs_tb_top.sv */
`timescale 1ns/1ps
module cgr_global_regs_tb_top
    import cgr_pkg::*;
();
    typedef struct packed {logic wr; logic [15:0] addr; logic [63:0] wdata; logic [63:0] exp;} cgr_row_t;

    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [63:0] reg_wdata_in = 64'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [63:0] reg_rdata_out;
    logic        err_valid_in = 1'b0;
    logic [5:0]  err_type_in = 6'h00;
    logic [57:0] err_detail_in = 58'h0;
    logic        req_valid_in = 1'b0;
    logic [31:0] req_addr_in = 32'h0;
    logic        prefetch_on_out, code_prefetch_on_out, custom_region_on_out, custom_hit_out;
    logic        err_response_out, err_corrected_out, err_irq_out;
    logic [7:0]  prefetch_port_select_out;
    logic [15:0] custom_base_out;
    int          errors = 0;
    int          comparisons = 0;
    logic [57:0] det = 58'h0ab_cdef_0123;
    cgr_row_t    rows [12] = '{
        '{1'b0, CGR_OFF_PF_CTRL,   64'h0,            64'h02},
        '{1'b1, CGR_OFF_PF_CTRL,   64'h1ff,          64'h102},
        '{1'b1, CGR_OFF_PF_PORTS,  64'h1ff,          64'h1ff},
        '{1'b1, CGR_OFF_ERR_MASK,  64'h0a,           64'h0a},
        '{1'b1, CGR_OFF_CUST_STAT, 64'h0,            64'h1},
        '{1'b1, CGR_OFF_CUST_BASE, 64'h1234_0001,    64'h1234_0001},
        '{1'b1, 16'h0100,          64'hffff,         64'h0},
        '{1'b1, CGR_OFF_SEMAPHORE, 64'h8000_0005,    64'h8000_0005},
        '{1'b1, CGR_OFF_SEMAPHORE, 64'h8000_0007,    64'h8000_0005},
        '{1'b1, CGR_OFF_SEMAPHORE, 64'h0000_0007,    64'h0000_0007},
        '{1'b1, CGR_OFF_SEMAPHORE, 64'h8000_0009,    64'h8000_0009},
        '{1'b1, CGR_OFF_ERR_MULT,  64'hfc00_0000_0000_0000, 64'h0}};

    always #5 clk_in = ~clk_in;

    cgr_global_regs i_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .err_valid_in(err_valid_in), .err_type_in(err_type_in), .err_detail_in(err_detail_in),
        .req_valid_in(req_valid_in), .req_addr_in(req_addr_in), .prefetch_on_out(prefetch_on_out),
        .code_prefetch_on_out(code_prefetch_on_out), .prefetch_port_select_out(prefetch_port_select_out),
        .custom_region_on_out(custom_region_on_out), .custom_base_out(custom_base_out),
        .custom_hit_out(custom_hit_out), .err_response_out(err_response_out),
        .err_corrected_out(err_corrected_out), .err_irq_out(err_irq_out));

    logic [63:0] rdata_bare;
    logic        pf_bare;
    logic        cust_on_bare;

    // second copy with no prefetch units and no custom block, fed the same bus
    cgr_global_regs #(.PREFETCH_UNITS(8'h00), .CUSTOM_PRESENT(1'b0)) i_dut_bare (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata_bare),
        .err_valid_in(err_valid_in), .err_type_in(err_type_in), .err_detail_in(err_detail_in),
        .req_valid_in(req_valid_in), .req_addr_in(req_addr_in), .prefetch_on_out(pf_bare),
        .code_prefetch_on_out(), .prefetch_port_select_out(), .custom_region_on_out(cust_on_bare),
        .custom_base_out(), .custom_hit_out(), .err_response_out(), .err_corrected_out(), .err_irq_out());

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk64({63'h0, got}, {63'h0, exp});
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [63:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // read data stands one cycle only, so sample just after the answering edge
    task automatic rd_chk(input logic [15:0] a, input logic [63:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk64(reg_rdata_out, exp);
    endtask

    task automatic err_pulse(input logic [5:0] t, input logic [57:0] d);
        @(posedge clk_in);
        err_valid_in <= 1'b1;
        err_type_in <= t;
        err_detail_in <= d;
        @(posedge clk_in);
        err_valid_in <= 1'b0;
        #1;
    endtask

    task automatic summarize();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk_in);
        errors++;
        summarize();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk1(prefetch_on_out | err_irq_out | custom_region_on_out, 1'b0);
        rd_chk(CGR_OFF_SEMAPHORE, 64'h0);
        $display("test reset done");
        foreach (rows[i])
        begin
            if (rows[i].wr)
                bus_wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        chk1(prefetch_on_out, 1'b1);
        chk1(code_prefetch_on_out, 1'b1);
        chk64({56'h0, prefetch_port_select_out}, 64'h3f);
        chk64({48'h0, custom_base_out}, 64'h1234);
        chk1(custom_region_on_out, 1'b1);
        chk1(pf_bare, 1'b0);
        chk1(cust_on_bare, 1'b0);
        rd_chk(CGR_OFF_CUST_STAT, 64'h1);
        chk64(rdata_bare, 64'h0);
        rd_chk(CGR_OFF_CUST_BASE, 64'h1234_0001);
        chk64(rdata_bare, 64'h1234_0000);
        $display("test register table done");
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_addr_in <= 32'h1234_5678;
        @(posedge clk_in);
        req_addr_in <= 32'h1235_0000;
        #1;
        chk1(custom_hit_out, 1'b1);
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        #1;
        chk1(custom_hit_out, 1'b0);
        $display("test custom decode done");
        err_pulse(CGR_ERR_REQ_DECODE, det);
        chk1(err_response_out, 1'b1);
        chk1(err_corrected_out, 1'b0);
        @(posedge clk_in);
        #1;
        chk1(err_irq_out, 1'b0);
        rd_chk(CGR_OFF_ERR_CAUSE, {CGR_ERR_REQ_DECODE, det});
        err_pulse(CGR_ERR_L2_FATAL, 58'h5);
        rd_chk(CGR_OFF_ERR_MULT, {CGR_ERR_L2_FATAL, 58'h0});
        rd_chk(CGR_OFF_ERR_CAUSE, {CGR_ERR_REQ_DECODE, det});
        bus_wr(CGR_OFF_ERR_CAUSE, {CGR_ERR_REQ_DECODE, 58'h0});
        rd_chk(CGR_OFF_ERR_CAUSE, {CGR_ERR_NONE, det});
        rd_chk(CGR_OFF_ERR_MULT, 64'h0);
        err_pulse(CGR_ERR_L2_FIXABLE, 58'h11);
        chk1(err_corrected_out, 1'b1);
        chk1(err_response_out, 1'b0);
        @(posedge clk_in);
        #1;
        chk1(err_irq_out, 1'b1);
        err_pulse(CGR_ERR_L2_FATAL, 58'h22);
        rd_chk(CGR_OFF_ERR_CAUSE, {CGR_ERR_L2_FATAL, 58'h22});
        rd_chk(CGR_OFF_ERR_MULT, 64'h0);
        chk1(err_irq_out, 1'b1);
        bus_wr(CGR_OFF_ERR_MASK, 64'h02);
        repeat (2) @(posedge clk_in);
        #1;
        chk1(err_irq_out, 1'b0);
        bus_wr(CGR_OFF_ERR_CAUSE, {CGR_ERR_L2_FIXABLE, 58'h0});
        rd_chk(CGR_OFF_ERR_CAUSE, {CGR_ERR_L2_FATAL, 58'h22});
        bus_wr(CGR_OFF_ERR_CAUSE, {CGR_ERR_L2_FATAL, 58'h0});
        rd_chk(CGR_OFF_ERR_CAUSE, {CGR_ERR_NONE, 58'h22});
        $display("test error capture done");
        bus_wr(CGR_OFF_SEMAPHORE, 64'h8000_0001);
        err_pulse(CGR_ERR_L2_FATAL, 58'h3);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd_chk(CGR_OFF_SEMAPHORE, 64'h0);
        rd_chk(CGR_OFF_ERR_CAUSE, 64'h0);
        rd_chk(CGR_OFF_ERR_MASK, 64'h0);
        chk1(prefetch_on_out, 1'b0);
        $display("test mid-run reset done");
        summarize();
    end
endmodule

bind cgr_global_regs cgr_global_regs_props #(
    .PREFETCH_UNITS(PREFETCH_UNITS), .NUM_CORES(NUM_CORES), .NUM_IO_UNITS(NUM_IO_UNITS),
    .CUSTOM_PRESENT(CUSTOM_PRESENT)) i_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .err_valid_in(err_valid_in), .err_type_in(err_type_in), .err_detail_in(err_detail_in),
    .req_valid_in(req_valid_in), .req_addr_in(req_addr_in), .prefetch_on_out(prefetch_on_out),
    .code_prefetch_on_out(code_prefetch_on_out), .prefetch_port_select_out(prefetch_port_select_out),
    .custom_region_on_out(custom_region_on_out), .custom_base_out(custom_base_out),
    .custom_hit_out(custom_hit_out), .err_response_out(err_response_out),
    .err_corrected_out(err_corrected_out), .err_irq_out(err_irq_out));
